// ==== hw/aost_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Byte addresses on an 8-bit AXI4-Lite address
// Notes: Definitions only
`ifndef AOST_CFG_SVH
`define AOST_CFG_SVH
// Register offsets
`define AOST_OFF_CTRL 8'h00
`define AOST_OFF_STROBE 8'h04
`define AOST_OFF_LOAD 8'h08
`define AOST_OFF_INT_EN 8'h28
`define AOST_OFF_INT_STAT 8'h2C
`define AOST_OFF_INT_ACK 8'h30
`define AOST_OFF_GRP_CFG 8'h34
`define AOST_OFF_SEC_CTRL 8'h38
`define AOST_OFF_STATE 8'h3C
`define AOST_NLOAD 8
// Control fields
`define AOST_CTRL_ARM 0
`define AOST_CTRL_STOP_END 1
`define AOST_CTRL_BLOCK 2
`define AOST_CTRL_DEFER 3
`define AOST_CTRL_QSEL_LO 4
`define AOST_CTRL_MUTE_A 6
`define AOST_CTRL_MUTE_B 7
`define AOST_CTRL_FIRST_B 8
`define AOST_CTRL_RST 9'h000
// Strobe fields
`define AOST_STB_START 0
`define AOST_STB_RATE 1
`define AOST_STB_SEC_SW 2
// Load register indices
`define AOST_LD_BC_A 0
`define AOST_LD_BC_B 1
`define AOST_LD_UC_A 2
`define AOST_LD_UC_B 3
`define AOST_LD_UI_A 4
`define AOST_LD_UI_B 5
`define AOST_LD_SEC_A 6
`define AOST_LD_SEC_B 7
// Event and status bits
`define AOST_NEV 13
`define AOST_EV_ERR 0
`define AOST_EV_STOP 1
`define AOST_EV_START 2
`define AOST_EV_TRIG 3
`define AOST_EV_BCTC 4
`define AOST_EV_UCTC 5
`define AOST_EV_FIFO 6
`define AOST_EV_UPD 7
`define AOST_EV_PT 8
`define AOST_EV_TRIGF 9
`define AOST_EV_BTF 10
`define AOST_EV_SECTC 11
`define AOST_EV_SECERR 12
`define AOST_SRC_MASK 13'h09FF
`define AOST_ACK_MASK 13'h1ABF
`define AOST_SUM_BIT 15
// Group configuration and secondary control
`define AOST_GRP_SEL_LO 0
`define AOST_GRP_EN 3
`define AOST_GRP_POL 4
`define AOST_GRP_RST 5'h00
`define AOST_SEC_ARM 0
`define AOST_SEC_FIRST_B 1
// Deferred start delay, output flop plus a slave synchroniser
`define AOST_DEFER_CYC 2'h3
`define AOST_RESP_OKAY 2'h0
`define AOST_RESP_SLVERR 2'h2
`endif

// ==== hw/aost_pkg.sv ====
// Purpose: Types for the staging block
// Assumes: Constants live in aost_cfg.svh
// Notes: Types only
package aost_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARMED = 4'h2,
    ST_DEFER = 4'h4,
    ST_RUN = 4'h8
  } aost_state_t;
  typedef enum logic [1:0] {
    QS_EMPTY = 2'h0,
    QS_HALF = 2'h1,
    QS_FULL = 2'h2
  } aost_qsel_t;
endpackage

// ==== hw/aost_counter.sv ====
// Purpose: Down counter with paired A/B load registers
// Assumes: Load values are the wanted count minus one
// Notes: Swap and terminal count in one cycle reload from the new side
`timescale 1ns/10ps
module aost_counter #(
  parameter int CW = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Sequencing
  input wire logic load,
  input wire logic firstB,
  input wire logic tick,
  input wire logic swap,
  // Paired load registers
  input wire logic [CW-1:0] loadA,
  input wire logic [CW-1:0] loadB,
  // Terminal count and selection
  output logic tc,
  output logic useB
);
  logic [CW-1:0] cnt_q;
  logic useB_q;
  logic nextB;

  // Terminal count is the tick that finds zero
  assign tc = tick && (cnt_q == {CW{1'b0}});
  assign nextB = useB_q ^ swap;
  assign useB = useB_q;

  // Selection flips on a swap, freeing the idle register for rewrite
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      useB_q <= 1'b0;
    end else if (load) begin
      useB_q <= firstB;
    end else begin
      useB_q <= nextB;
    end
  end

  // Count down; running count never sees a load register write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {CW{1'b0}};
    end else if (load) begin
      cnt_q <= firstB ? loadB : loadA;
    end else if (tc) begin
      cnt_q <= nextB ? loadB : loadA;
    end else if (tick) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ==== hw/aost_top.sv ====
// Purpose: Staging, timing and group B interrupts of the analog output
//   timing module, primary and secondary counter groups
// Assumes: Event pins asynchronous; one AXI4-Lite write and read at once
// Notes: Operation below
// Operation
// - Buffer, update, interval counters each have A/B loads; values are count minus one
// - Stop-at-buffer-count-end set stops generation at next buffer terminal count
// - Buffer terminal count status stays until software writes its acknowledge one
// - Start trigger during last stage sets stage trigger fault; confirm clears it
// - Unserviced buffer terminal count sets buffer fault; only reprogramming recovers
// - Immediate rate change waits for one update at old interval, else sequence end
// - Error, trigger, buffer, update count, update events have enable/status/ack; queue has enable/status only
// - Overrun or overflow raises error event in overrun flag; acknowledge clears
// - Queue condition select picks full, half or empty; no acknowledge, follows state
// - All events but stage trigger fault, buffer fault and secondary error feed group two; 3-bit line select and group enable gate it
// - Group two summary flag shows any pending group source
// - Interrupt line polarity chosen by configuration bit
// - Pass-through interrupt input also feeds group two
// - Stop and start events have bits but no function
// - Primary group of three counters plus independent secondary interval counter
// - Status bits readable with interrupts disabled, for polling
// - Load registers writable while sequence runs, running counters undisturbed
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "aost_cfg.svh"
module aost_top #(
  parameter int CW = 24
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event pins
  input wire logic startTrigIn,
  input wire logic overrunIn,
  input wire logic overflowIn,
  input wire logic queueFullIn,
  input wire logic queueHalfIn,
  input wire logic queueEmptyIn,
  input wire logic passThroughIn,
  // Outputs
  output logic startTrigOut,
  output logic updateOut,
  output logic secUpdateOut,
  output logic [7:0] irqLine
);
  import aost_pkg::*;

  logic [6:0] pinRaw;
  logic [6:0] syncA_q;
  logic [6:0] syncB_q;
  logic [6:0] syncC_q;
  logic trigEdge, errEdge, trigRaw, trigAcc, running, muted;
  logic wrEn, rdEn, primLoad, disarm, secLoad, req, summary, qLvl, stopHit;
  logic [2:0] stbW;
  logic [12:0] ackW, evSet, clr, statView;
  logic [8:0] ctrl_q;
  logic [12:0] intEn_q, stat_q;
  logic [4:0] grpCfg_q;
  logic [1:0] secCtrl_q;
  logic [CW-1:0] ld_q [0:`AOST_NLOAD-1];
  logic [31:0] rdVal;
  logic [1:0] deferCnt_q;
  aost_state_t state_q;
  logic ratePend_q, updSeen_q, secSwPend_q;
  logic uiTc, ucTc, bcTc, secTc, uiSwap, rateNow;
  logic uiUseB, ucUseB, bcUseB, secUseB;

  // Pin synchronisers; edge logic reads only the second and third flop
  assign pinRaw = {passThroughIn, queueEmptyIn, queueHalfIn, queueFullIn,
                   overflowIn, overrunIn, startTrigIn};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= 7'h00;
      syncB_q <= 7'h00;
      syncC_q <= 7'h00;
    end else begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end
  assign trigEdge = syncB_q[0] & ~syncC_q[0];
  assign errEdge = (syncB_q[1] & ~syncC_q[1]) | (syncB_q[2] & ~syncC_q[2]);

  // Byte-lane merge for register writes
  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      mergeStrb[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // Whole map is contiguous, so alignment and top bound decide
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= `AOST_OFF_STATE);
  endfunction

  // Write channel: address and data taken together, response follows
  assign wrEn = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                !s_axi_bvalid;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AOST_RESP_OKAY;
    end else begin
      s_axi_awready <= wrEn;
      s_axi_wready <= wrEn;
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(s_axi_awaddr) ? `AOST_RESP_OKAY :
                       `AOST_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data registered one cycle after the address
  assign rdEn = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AOST_RESP_OKAY;
    end else begin
      s_axi_arready <= rdEn;
      if (rdEn) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdVal;
        s_axi_rresp <= isMapped(s_axi_araddr) ? `AOST_RESP_OKAY :
                       `AOST_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Write-one strobes act in the write cycle and store nothing
  assign stbW = (wrEn && s_axi_awaddr == `AOST_OFF_STROBE && s_axi_wstrb[0])
                ? s_axi_wdata[2:0] : 3'h0;
  assign ackW = (wrEn && s_axi_awaddr == `AOST_OFF_INT_ACK) ?
                13'(mergeStrb(32'h0000_0000, s_axi_wdata, s_axi_wstrb)) &
                `AOST_ACK_MASK : 13'h0000;
  assign primLoad = wrEn && s_axi_awaddr == `AOST_OFF_CTRL && s_axi_wstrb[0]
                    && s_axi_wdata[`AOST_CTRL_ARM] && state_q == ST_IDLE;
  assign disarm = wrEn && s_axi_awaddr == `AOST_OFF_CTRL && s_axi_wstrb[0]
                  && !s_axi_wdata[`AOST_CTRL_ARM];
  assign secLoad = wrEn && s_axi_awaddr == `AOST_OFF_SEC_CTRL &&
                   s_axi_wstrb[0] && s_axi_wdata[`AOST_SEC_ARM] &&
                   !secCtrl_q[`AOST_SEC_ARM];

  // Register file; load registers stay writable during a run
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `AOST_CTRL_RST;
      intEn_q <= 13'h0000;
      grpCfg_q <= `AOST_GRP_RST;
      secCtrl_q <= 2'h0;
      for (int i = 0; i < `AOST_NLOAD; i++) begin
        ld_q[i] <= {CW{1'b0}};
      end
    end else if (wrEn) begin
      if (s_axi_awaddr == `AOST_OFF_CTRL) begin
        ctrl_q <= 9'(mergeStrb(32'(ctrl_q), s_axi_wdata, s_axi_wstrb));
      end
      if (s_axi_awaddr == `AOST_OFF_INT_EN) begin
        intEn_q <= 13'(mergeStrb(32'(intEn_q), s_axi_wdata, s_axi_wstrb));
      end
      if (s_axi_awaddr == `AOST_OFF_GRP_CFG) begin
        grpCfg_q <= 5'(mergeStrb(32'(grpCfg_q), s_axi_wdata, s_axi_wstrb));
      end
      if (s_axi_awaddr == `AOST_OFF_SEC_CTRL) begin
        secCtrl_q <= 2'(mergeStrb(32'(secCtrl_q), s_axi_wdata, s_axi_wstrb));
      end
      for (int i = 0; i < `AOST_NLOAD; i++) begin
        if (s_axi_awaddr == `AOST_OFF_LOAD + 8'(4 * i)) begin
          ld_q[i] <= CW'(mergeStrb(32'(ld_q[i]), s_axi_wdata,
                                   s_axi_wstrb));
        end
      end
      // Stop still drops arm when a write lands in the same cycle
      if (stopHit) begin
        ctrl_q[`AOST_CTRL_ARM] <= 1'b0;
      end
    end else if (stopHit) begin
      ctrl_q[`AOST_CTRL_ARM] <= 1'b0;
    end
  end

  // Start trigger; block holds off the master until slaves are ready
  assign trigRaw = trigEdge | stbW[`AOST_STB_START];
  assign trigAcc = trigRaw && !ctrl_q[`AOST_CTRL_BLOCK];
  assign running = state_q == ST_RUN;
  assign stopHit = running && bcTc && ctrl_q[`AOST_CTRL_STOP_END];

  // Sequencer: arm loads counters, trigger runs, stop at last sequence
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      deferCnt_q <= 2'h0;
    end else begin
      deferCnt_q <= (state_q == ST_DEFER) ? deferCnt_q + 2'h1 : 2'h0;
      case (state_q)
        ST_IDLE: begin
          if (primLoad) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (disarm) begin
            state_q <= ST_IDLE;
          end else if (trigAcc) begin
            state_q <= ctrl_q[`AOST_CTRL_DEFER] ? ST_DEFER : ST_RUN;
          end
        end
        ST_DEFER: begin
          if (disarm) begin
            state_q <= ST_IDLE;
          end else if (deferCnt_q == `AOST_DEFER_CYC - 2'h1) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (disarm || (bcTc && ctrl_q[`AOST_CTRL_STOP_END])) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Primary group chained: interval, then update count, then buffer count
  aost_counter #(.CW(CW)) uInterval (
    .core_clk(core_clk), .arst_n(arst_n), .load(primLoad),
    .firstB(ctrl_q[`AOST_CTRL_FIRST_B]), .tick(running), .swap(uiSwap),
    .loadA(ld_q[`AOST_LD_UI_A]), .loadB(ld_q[`AOST_LD_UI_B]),
    .tc(uiTc), .useB(uiUseB));
  aost_counter #(.CW(CW)) uUpdCount (
    .core_clk(core_clk), .arst_n(arst_n), .load(primLoad),
    .firstB(ctrl_q[`AOST_CTRL_FIRST_B]), .tick(uiTc), .swap(bcTc),
    .loadA(ld_q[`AOST_LD_UC_A]), .loadB(ld_q[`AOST_LD_UC_B]),
    .tc(ucTc), .useB(ucUseB));
  aost_counter #(.CW(CW)) uBufCount (
    .core_clk(core_clk), .arst_n(arst_n), .load(primLoad),
    .firstB(ctrl_q[`AOST_CTRL_FIRST_B]), .tick(ucTc), .swap(bcTc),
    .loadA(ld_q[`AOST_LD_BC_A]), .loadB(ld_q[`AOST_LD_BC_B]),
    .tc(bcTc), .useB(bcUseB));
  aost_counter #(.CW(CW)) uSecInterval (
    .core_clk(core_clk), .arst_n(arst_n), .load(secLoad),
    .firstB(s_axi_wdata[`AOST_SEC_FIRST_B]),
    .tick(secCtrl_q[`AOST_SEC_ARM]), .swap(secTc && secSwPend_q),
    .loadA(ld_q[`AOST_LD_SEC_A]), .loadB(ld_q[`AOST_LD_SEC_B]),
    .tc(secTc), .useB(secUseB));

  // Rate change applies early only after one update at the old interval
  assign rateNow = uiTc && ratePend_q && updSeen_q;
  assign uiSwap = bcTc || rateNow;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ratePend_q <= 1'b0;
      updSeen_q <= 1'b0;
      secSwPend_q <= 1'b0;
    end else begin
      ratePend_q <= stbW[`AOST_STB_RATE] || (ratePend_q && !uiSwap);
      updSeen_q <= uiTc && !uiSwap || (updSeen_q && !uiSwap && !primLoad);
      secSwPend_q <= stbW[`AOST_STB_SEC_SW] || (secSwPend_q && !secTc);
    end
  end

  // Muting follows the register pair of the running buffer sequence
  assign muted = bcUseB ? ctrl_q[`AOST_CTRL_MUTE_B] :
                 ctrl_q[`AOST_CTRL_MUTE_A];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      updateOut <= 1'b0;
      secUpdateOut <= 1'b0;
      startTrigOut <= 1'b0;
    end else begin
      updateOut <= uiTc && !muted;
      secUpdateOut <= secTc;
      startTrigOut <= trigAcc && state_q == ST_ARMED;
    end
  end

  // Event sources; stop and start exist only as bits
  always_comb begin
    evSet = 13'h0000;
    evSet[`AOST_EV_ERR] = errEdge;
    evSet[`AOST_EV_TRIG] = trigAcc && state_q == ST_ARMED;
    evSet[`AOST_EV_BCTC] = bcTc;
    evSet[`AOST_EV_UCTC] = ucTc;
    evSet[`AOST_EV_UPD] = uiTc;
    evSet[`AOST_EV_TRIGF] = trigRaw && running &&
                            ctrl_q[`AOST_CTRL_STOP_END];
    evSet[`AOST_EV_BTF] = bcTc && stat_q[`AOST_EV_BCTC] &&
                          !ackW[`AOST_EV_BCTC];
    evSet[`AOST_EV_SECTC] = secTc;
    evSet[`AOST_EV_SECERR] = secTc && stat_q[`AOST_EV_SECTC] &&
                             !ackW[`AOST_EV_SECTC];
  end

  // Buffer fault survives acknowledge; only a disarm clears it
  always_comb begin
    clr = ackW;
    clr[`AOST_EV_BTF] = disarm;
  end

  // Sticky status, set beats clear, enables never consulted
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 13'h0000;
    end else begin
      stat_q <= (stat_q & ~clr) | evSet;
    end
  end

  // Queue bit follows the pin state itself and cannot be acknowledged
  always_comb begin
    case (aost_qsel_t'(ctrl_q[`AOST_CTRL_QSEL_LO +: 2]))
      QS_FULL: qLvl = syncB_q[3];
      QS_HALF: qLvl = syncB_q[4];
      default: qLvl = syncB_q[5];
    endcase
  end
  always_comb begin
    statView = stat_q;
    statView[`AOST_EV_FIFO] = qLvl;
    statView[`AOST_EV_PT] = syncB_q[6];
  end

  // Group two: summary is ungated, the request is gated
  assign summary = |(statView & `AOST_SRC_MASK);
  assign req = grpCfg_q[`AOST_GRP_EN] &&
               |(statView & intEn_q & `AOST_SRC_MASK);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqLine <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        irqLine[i] <= (req && grpCfg_q[2:0] == 3'(i)) ?
                      grpCfg_q[`AOST_GRP_POL] :
                      !grpCfg_q[`AOST_GRP_POL];
      end
    end
  end

  // Read decode; strobe and acknowledge words read as zero
  always_comb begin
    rdVal = 32'h0000_0000;
    case (s_axi_araddr)
      `AOST_OFF_CTRL: rdVal = 32'(ctrl_q);
      `AOST_OFF_INT_EN: rdVal = 32'(intEn_q);
      `AOST_OFF_INT_STAT: rdVal = {16'h0000, summary, 2'h0, statView};
      `AOST_OFF_GRP_CFG: rdVal = 32'(grpCfg_q);
      `AOST_OFF_SEC_CTRL: rdVal = 32'(secCtrl_q);
      `AOST_OFF_STATE: rdVal = {26'h0000000, secUseB, uiUseB, ucUseB,
                                bcUseB, updSeen_q, running};
      default: rdVal = 32'h0000_0000;
    endcase
    for (int i = 0; i < `AOST_NLOAD; i++) begin
      if (s_axi_araddr == `AOST_OFF_LOAD + 8'(4 * i)) begin
        rdVal = 32'(ld_q[i]);
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_stop_at_end: assert property (
    running && bcTc && ctrl_q[`AOST_CTRL_STOP_END] |=> state_q == ST_IDLE)
    else $error("generation did not stop at buffer terminal count");
  a_ack_clears: assert property (
    ackW[`AOST_EV_BCTC] && !bcTc |=> !stat_q[`AOST_EV_BCTC])
    else $error("buffer terminal status not cleared by acknowledge");
  a_latch_no_enable: assert property (
    uiTc && !intEn_q[`AOST_EV_UPD] |=> stat_q[`AOST_EV_UPD])
    else $error("update status not latched while disabled");
  a_trig_fault: assert property (
    trigRaw && running && ctrl_q[`AOST_CTRL_STOP_END]
    |=> stat_q[`AOST_EV_TRIGF])
    else $error("stage trigger fault not flagged");
  a_buf_fault: assert property (
    bcTc && stat_q[`AOST_EV_BCTC] && !ackW[`AOST_EV_BCTC]
    |=> stat_q[`AOST_EV_BTF] ##1 stat_q[`AOST_EV_BTF] || $past(disarm))
    else $error("buffer terminal fault not flagged");
  a_rate_wait: assert property (
    $changed(uiUseB) && !$past(bcTc) && !$past(primLoad)
    |-> $past(updSeen_q && ratePend_q))
    else $error("interval swapped before an update at the old rate");
  a_irq_line: assert property (
    req |=> irqLine[$past(grpCfg_q[2:0])] == $past(grpCfg_q[4]))
    else $error("selected line not asserted");
  a_summary_flag: assert property (
    stat_q[`AOST_EV_BCTC] && !intEn_q[`AOST_EV_BCTC] |-> summary)
    else $error("summary misses a pending source");
  a_idle_polarity: assert property (
    !req |=> irqLine == {8{!$past(grpCfg_q[4])}})
    else $error("idle line level wrong for polarity");
  a_ack_reads_zero: assert property (
    rdEn && s_axi_araddr == `AOST_OFF_INT_ACK |=> s_axi_rdata == 32'h0)
    else $error("acknowledge word read non-zero");

  c_stage_swap: cover property (running && bcTc && !stat_q[`AOST_EV_BCTC]);
  c_trig_fault: cover property (evSet[`AOST_EV_TRIGF]);
  c_rate_now: cover property (rateNow && !bcTc);
  c_deferred: cover property (state_q == ST_DEFER ##3 state_q == ST_RUN);
endmodule

// ==== verif/test_aost_top.sv ====
// Purpose: Self-checking bench for the staging and group B interrupt block
// Assumes: Offsets and bit positions as in aost_cfg.svh; CW shrunk to 8
// Notes: Register table loop first, then hand-written event cases
`timescale 1ns/10ps
`include "aost_cfg.svh"
module test_aost_top;
  typedef struct packed {
    logic [7:0] a;
    logic wr;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } aost_row_t;
  // Address, write flag, data, read-back, response
  localparam aost_row_t ROWS [6] = '{
    '{`AOST_OFF_CTRL, 1'b0, 32'h0, 32'h0, `AOST_RESP_OKAY},
    '{`AOST_OFF_STROBE, 1'b0, 32'h0, 32'h0, `AOST_RESP_OKAY},
    '{`AOST_OFF_LOAD, 1'b1, 32'hFFABCDEF, 32'hEF, `AOST_RESP_OKAY},
    '{`AOST_OFF_GRP_CFG, 1'b1, 32'h1F, 32'h1F, `AOST_RESP_OKAY},
    '{`AOST_OFF_INT_ACK, 1'b1, 32'h1FFF, 32'h0, `AOST_RESP_OKAY},
    '{8'h40, 1'b1, 32'h5, 32'h0, `AOST_RESP_SLVERR}};
  logic core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, irqLine;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic startTrigIn, overrunIn, overflowIn, queueFullIn, queueHalfIn;
  logic queueEmptyIn, passThroughIn, startTrigOut, updateOut, secUpdateOut;
  int mismatches, compares, cycles, updCnt, trigCnt, secCnt, secSnap;
  aost_top #(.CW(8)) dut_u (.core_clk, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .startTrigIn, .overrunIn, .overflowIn, .queueFullIn, .queueHalfIn,
    .queueEmptyIn, .passThroughIn, .startTrigOut, .updateOut,
    .secUpdateOut, .irqLine);
  // Clock, 20 ns period
  always #10 core_clk = ~core_clk;
  // Watchdog and update pulse count
  always @(posedge core_clk) begin
    cycles++;
    if (updateOut === 1'b1) updCnt++;
    if (startTrigOut === 1'b1) trigCnt++;
    if (secUpdateOut === 1'b1) secCnt++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Address and data offered together, held until taken
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdReg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  // Status read and compare in one go
  task automatic stat(input logic [31:0] e);
    rdReg(`AOST_OFF_INT_STAT);
    chk("status", rd, e);
  endtask
  // Main sequence
  initial begin
    {core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {startTrigIn, overrunIn, overflowIn, queueFullIn, queueHalfIn} = '0;
    {queueEmptyIn, passThroughIn, s_axi_wdata} = '0;
    {mismatches, compares, cycles, updCnt, trigCnt, secCnt, secSnap} = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    chk("idle line", irqLine, 32'hFF);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wrReg(ROWS[i].a, ROWS[i].d);
      if (ROWS[i].wr) chk("wresp", rs, ROWS[i].r);
      rdReg(ROWS[i].a);
      chk("rdata", rd, ROWS[i].e);
      chk("rresp", rs, ROWS[i].r);
    end
    // Pass-through source, line 2 active high, then low, then masked
    wrReg(`AOST_OFF_INT_EN, 32'h1FFF);
    wrReg(`AOST_OFF_GRP_CFG, 32'h1A);
    passThroughIn <= 1'b1;
    repeat (5) @(posedge core_clk);
    stat(32'h8100);
    chk("line high", irqLine, 32'h04);
    wrReg(`AOST_OFF_GRP_CFG, 32'h0A);
    chk("line low", irqLine, 32'hFB);
    wrReg(`AOST_OFF_INT_EN, 32'h0);
    chk("masked", irqLine, 32'hFF);
    stat(32'h8100);
    passThroughIn <= 1'b0;
    repeat (5) @(posedge core_clk);
    stat(32'h0);
    // Overflow edge raises the error event, acknowledge clears it
    overflowIn <= 1'b1;
    @(posedge core_clk);
    overflowIn <= 1'b0;
    repeat (5) @(posedge core_clk);
    stat(32'h8001);
    wrReg(`AOST_OFF_INT_ACK, 32'h1);
    stat(32'h0);
    // Queue empty follows the pin, ignores acknowledge, hidden once full is selected
    queueEmptyIn <= 1'b1;
    repeat (5) @(posedge core_clk);
    stat(32'h8040);
    wrReg(`AOST_OFF_INT_ACK, 32'h40);
    stat(32'h8040);
    wrReg(`AOST_OFF_CTRL, 32'h20);
    stat(32'h0);
    wrReg(`AOST_OFF_CTRL, 32'h0);
    queueEmptyIn <= 1'b0;
    repeat (5) @(posedge core_clk);
    stat(32'h0);
    // One buffer of two updates, three clocks apart, stop at its end
    // Last stage of one buffer, each load programmed one below its count; end marker next
    wrReg(`AOST_OFF_LOAD, 32'h0);
    wrReg(`AOST_OFF_LOAD + 8'h08, 32'h1);
    wrReg(`AOST_OFF_LOAD + 8'h10, 32'h2);
    wrReg(`AOST_OFF_CTRL, 32'h3);
    wrReg(`AOST_OFF_STROBE, 32'h1);
    rd = '0;
    for (int k = 0; k < 40 && rd[`AOST_EV_BCTC] !== 1'b1; k++) begin
      rdReg(`AOST_OFF_INT_STAT);
    end
    chk("buffer_count_terminal", rd & 32'hB0, 32'hB0);
    repeat (20) @(posedge core_clk);
    chk("updates", updCnt, 32'h2);
    rdReg(`AOST_OFF_CTRL);
    chk("stopped", rd, 32'h2);
    wrReg(`AOST_OFF_INT_ACK, 32'h10);
    rdReg(`AOST_OFF_INT_STAT);
    chk("bc ack", rd & 32'h10, 32'h0);
    // Stage done: all three pairs swapped, opposite register reloaded
    rdReg(`AOST_OFF_STATE);
    chk("swapped", rd, 32'h1C);
    wrReg(`AOST_OFF_LOAD + 8'h08, 32'h0);
    rdReg(`AOST_OFF_LOAD + 8'h08);
    chk("uc reload", rd, 32'h0);
    // Master set-up: blocked triggers ignored, then a deferred start
    wrReg(`AOST_OFF_INT_ACK, 32'h1FFF);
    wrReg(`AOST_OFF_CTRL, 32'hD);
    startTrigIn <= 1'b1;
    @(posedge core_clk);
    startTrigIn <= 1'b0;
    wrReg(`AOST_OFF_STROBE, 32'h1);
    rdReg(`AOST_OFF_INT_STAT);
    chk("blocked", rd & 32'h8, 32'h0);
    wrReg(`AOST_OFF_CTRL, 32'h9);
    wrReg(`AOST_OFF_STROBE, 32'h1);
    rdReg(`AOST_OFF_STATE);
    chk("deferred", rd & 32'h1, 32'h0);
    repeat (4) @(posedge core_clk);
    rdReg(`AOST_OFF_STATE);
    chk("running", rd & 32'h1, 32'h1);
    chk("triggers", trigCnt, 32'h2);
    wrReg(`AOST_OFF_CTRL, 32'h0);
    // Secondary group: run, then the software reset sequence
    wrReg(`AOST_OFF_LOAD + 8'h18, 32'h1);
    wrReg(`AOST_OFF_SEC_CTRL, 32'h1);
    repeat (6) @(posedge core_clk);
    rdReg(`AOST_OFF_INT_STAT);
    chk("sec tc", rd & 32'h1800, 32'h1800);
    chk("sec pulses", 32'(secCnt > 2), 32'h1);
    wrReg(`AOST_OFF_SEC_CTRL, 32'h0);
    wrReg(`AOST_OFF_INT_ACK, 32'h1800);
    secSnap = secCnt;
    repeat (10) @(posedge core_clk);
    chk("sec quiet", secCnt, secSnap);
    rdReg(`AOST_OFF_INT_STAT);
    chk("sec cleared", rd & 32'h1800, 32'h0);
    // Reset while idle: interrupt lines drop, group configuration returns to default
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("reset line", irqLine, 32'h0);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("line after reset", irqLine, 32'hFF);
    rdReg(`AOST_OFF_GRP_CFG);
    chk("cfg after reset", rd, 32'h0);
    give_verdict();
  end
endmodule
